// ==== rtl/bridge_ctrl_defines.svh ====
// Constants for the bridge control discard timer block.
// Included by the package and the block; definitions only.
`ifndef BRIDGE_CTRL_DEFINES_SVH
`define BRIDGE_CTRL_DEFINES_SVH

// Register byte addresses
`define OFF_CTRL 8'h3c
`define OFF_IRQ_STAT 8'h40
`define OFF_IRQ_MASK 8'h44

// Control register fields
`define B_ERR_EN 27
`define B_STAT 26
`define B_TMO_SEL 25
`define B_PRI_TMO 24
`define B_FAST_B2B 23
`define B_SRESET 22
`define CTRL_RST 32'h0000_00ff
`define LINE_RST 8'hff

// Interrupt status fields
`define IRQ_W 3
`define IRQ_DISCARD 0
`define IRQ_DONE 1
`define IRQ_SREL 2

// Discard intervals in secondary clocks
`define TICKS_LONG 32'd32768
`define TICKS_SHORT 32'd1024
`define CNT_W 16

`endif

// ==== rtl/bridge_ctrl_pkg.sv ====
// Types for the bridge control discard timer block.
// Needs bridge_ctrl_defines.svh on the include path.
`include "bridge_ctrl_defines.svh"

package bridge_ctrl_pkg;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_COUNT = 2'b10
	} fsm_t;

	typedef struct packed {
		logic sc_meta;
		logic sc_sync;
		logic sc_prev;
		logic md_meta;
		logic md_sync;
		fsm_t fsm;
		logic [`CNT_W-1:0] cnt;
		logic err_en;
		logic tmo_sel;
		logic sreset;
		logic stat;
		logic [7:0] int_line;
		logic [`IRQ_W-1:0] irq_st;
		logic [`IRQ_W-1:0] irq_mk;
		logic ack;
		logic [31:0] rdata;
		logic discard;
		logic msg_v;
		logic msg_fatal;
	} state_t;

endpackage

// ==== rtl/bridge_control_discard_timer.sv ====
// Bridge control register slice with secondary discard timer.
// Assumes a classic Wishbone master on clk, a secondary PCI
// clock and mode pin from outside, and queue logic on clk.
`timescale 1ns/1ps
`default_nettype none
`include "bridge_ctrl_defines.svh"

module bridge_control_discard_timer #(
	parameter logic [31:0] TICKS_LONG = `TICKS_LONG,
	parameter logic [31:0] TICKS_SHORT = `TICKS_SHORT
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Secondary bus pins
	input wire logic sec_pci_clk,
	input wire logic sec_pci_mode,
	output logic sec_rst_n_o,
	output logic sec_init_o,
	output logic fast_b2b_o,
	// Delayed transaction queue
	input wire logic dt_head_i,
	input wire logic dt_done_i,
	output logic dt_discard_o,
	// Error reporting
	input wire logic aer_supported_i,
	input wire logic aer_fatal_i,
	input wire logic aer_mask_i,
	output logic err_msg_o,
	output logic err_fatal_o,
	// Interrupt
	output logic irq_o
);
	import bridge_ctrl_pkg::*;

	// ----------------------------------------
	// Decoding
	// ----------------------------------------
	function automatic logic hit(
		input logic [7:0] a,
		input logic [7:0] off
	);
		hit = (a[7:2] == off[7:2]);
	endfunction

	state_t s;
	state_t n;
	logic req;
	logic wr;
	logic rd;
	logic tick;
	logic expire;
	logic [`CNT_W-1:0] last;
	logic msg_go;
	logic [31:0] ctrl_val;

	// Reset value of the control register, picked apart bit by bit
	localparam logic [31:0] CTRL_RST_V = `CTRL_RST;

	// ----------------------------------------
	// Bus strobes
	// ----------------------------------------
	always_comb begin
		req = wb_cyc_i & wb_stb_i & ~s.ack;
		wr = wb_cyc_i & wb_stb_i & wb_we_i & s.ack;
		rd = wb_cyc_i & wb_stb_i & ~wb_we_i & s.ack;
	end

	// ----------------------------------------
	// Timer terms
	// ----------------------------------------
	always_comb begin
		tick = s.sc_sync & ~s.sc_prev;
		if (s.tmo_sel) begin
			last = TICKS_SHORT[`CNT_W-1:0] - 1'b1;
		end else begin
			last = TICKS_LONG[`CNT_W-1:0] - 1'b1;
		end
		expire = (s.fsm == ST_COUNT) & tick & (s.cnt == last)
			& ~dt_done_i & s.md_sync;
		msg_go = s.err_en
			| (aer_supported_i & ~aer_mask_i);
	end

	// ----------------------------------------
	// Register read view
	// ----------------------------------------
	always_comb begin
		ctrl_val = 32'h0000_0000;
		ctrl_val[`B_ERR_EN] = s.err_en;
		ctrl_val[`B_STAT] = s.stat;
		ctrl_val[`B_TMO_SEL] = s.tmo_sel;
		ctrl_val[`B_PRI_TMO] = 1'b0;
		ctrl_val[`B_FAST_B2B] = 1'b0;
		ctrl_val[`B_SRESET] = s.sreset;
		ctrl_val[7:0] = s.int_line;
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		n = s;
		n.sc_meta = sec_pci_clk;
		n.sc_sync = s.sc_meta;
		n.sc_prev = s.sc_sync;
		n.md_meta = sec_pci_mode;
		n.md_sync = s.md_meta;
		n.discard = 1'b0;
		n.msg_v = 1'b0;
		n.ack = req;
		n.rdata = s.rdata;

		// Read data is captured as the request is taken
		if (req) begin
			if (hit(wb_adr_i, `OFF_CTRL)) begin
				n.rdata = ctrl_val;
			end else if (hit(wb_adr_i, `OFF_IRQ_STAT)) begin
				n.rdata = {29'h0, s.irq_st};
			end else if (hit(wb_adr_i, `OFF_IRQ_MASK)) begin
				n.rdata = {29'h0, s.irq_mk};
			end else begin
				n.rdata = 32'h0000_0000;
			end
		end

		// Writes take effect at the acknowledging edge
		if (wr && hit(wb_adr_i, `OFF_CTRL)) begin
			if (wb_sel_i[3]) begin
				n.err_en = wb_dat_i[`B_ERR_EN];
				n.tmo_sel = wb_dat_i[`B_TMO_SEL];
				if (wb_dat_i[`B_STAT]) begin
					n.stat = 1'b0;
				end
			end
			if (wb_sel_i[2]) begin
				n.sreset = wb_dat_i[`B_SRESET];
			end
			if (wb_sel_i[0]) begin
				n.int_line = wb_dat_i[7:0];
			end
		end
		if (wr && hit(wb_adr_i, `OFF_IRQ_MASK) && wb_sel_i[0]) begin
			n.irq_mk = wb_dat_i[`IRQ_W-1:0];
		end
		if (rd && hit(wb_adr_i, `OFF_IRQ_STAT)) begin
			n.irq_st = '0;
		end

		// Discard timer
		unique case (s.fsm)
			ST_IDLE: begin
				n.cnt = '0;
				if (dt_head_i && s.md_sync && !s.sreset) begin
					n.fsm = ST_COUNT;
				end
			end
			ST_COUNT: begin
				if (dt_done_i) begin
					n.fsm = ST_IDLE;
					n.cnt = '0;
					n.irq_st[`IRQ_DONE] = 1'b1;
				end else if (expire) begin
					n.fsm = ST_IDLE;
					n.cnt = '0;
					n.discard = 1'b1;
					n.stat = 1'b1;
					n.irq_st[`IRQ_DISCARD] = 1'b1;
					n.msg_v = msg_go;
					n.msg_fatal = aer_supported_i & aer_fatal_i;
				end else if (!s.md_sync) begin
					n.fsm = ST_IDLE;
					n.cnt = '0;
				end else if (tick) begin
					n.cnt = s.cnt + 1'b1;
				end
			end
			default: begin
				n.fsm = ST_IDLE;
				n.cnt = '0;
			end
		endcase

		// Secondary side held at default while reset is on
		if (s.sreset) begin
			n.fsm = ST_IDLE;
			n.cnt = '0;
			n.discard = 1'b0;
			n.msg_v = 1'b0;
		end
		if (s.sreset && !n.sreset) begin
			n.irq_st[`IRQ_SREL] = 1'b1;
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s.sc_meta <= 1'b0;
			s.sc_sync <= 1'b0;
			s.sc_prev <= 1'b0;
			s.md_meta <= 1'b0;
			s.md_sync <= 1'b0;
			s.fsm <= ST_IDLE;
			s.cnt <= '0;
			s.err_en <= CTRL_RST_V[`B_ERR_EN];
			s.tmo_sel <= CTRL_RST_V[`B_TMO_SEL];
			s.sreset <= CTRL_RST_V[`B_SRESET];
			s.stat <= CTRL_RST_V[`B_STAT];
			s.int_line <= `LINE_RST;
			s.irq_st <= '0;
			s.irq_mk <= '0;
			s.ack <= 1'b0;
			s.rdata <= 32'h0000_0000;
			s.discard <= 1'b0;
			s.msg_v <= 1'b0;
			s.msg_fatal <= 1'b0;
		end else begin
			s <= n;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	always_comb begin
		wb_ack_o = s.ack;
		wb_dat_o = s.rdata;
		sec_rst_n_o = ~s.sreset;
		sec_init_o = s.sreset;
		fast_b2b_o = 1'b0;
		dt_discard_o = s.discard;
		err_msg_o = s.msg_v;
		err_fatal_o = s.msg_fatal;
		irq_o = |(s.irq_st & s.irq_mk);
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	a_start_count: assert property (
		s.fsm == ST_IDLE && dt_head_i && s.md_sync && !s.sreset
		|=> s.fsm == ST_COUNT
	) else $error("count did not start at queue head");

	a_no_count_pcix: assert property (
		!s.md_sync && !s.sreset && !dt_head_i
		|=> s.fsm == ST_IDLE
	) else $error("timer counting outside PCI mode");

	a_expire_discard: assert property (
		expire && !s.sreset |=> s.discard && s.stat
	) else $error("expiry did not discard");

	a_stat_sticky: assert property (
		s.stat && !(wr && hit(wb_adr_i, `OFF_CTRL)
			&& wb_sel_i[3] && wb_dat_i[`B_STAT])
		|=> s.stat
	) else $error("status cleared without write one");

	a_stat_cause: assert property (
		$rose(s.stat) |-> s.discard
	) else $error("status set without discard");

	a_msg_sent: assert property (
		s.discard |-> s.msg_v == $past(msg_go)
	) else $error("message not matched to enable");

	a_msg_gated: assert property (
		s.msg_v |-> s.discard
			&& ($past(s.err_en) || $past(aer_supported_i))
	) else $error("message sent without cause");

	a_fixed_zero: assert property (
		s.ack && !wb_we_i && hit(wb_adr_i, `OFF_CTRL)
		|-> !wb_dat_o[`B_PRI_TMO] && !wb_dat_o[`B_FAST_B2B]
			&& !fast_b2b_o
	) else $error("read-only bits not zero");

	a_sreset_pin: assert property (
		s.sreset[*2] |-> !sec_rst_n_o && sec_init_o
			&& !$past(sec_rst_n_o)
	) else $error("secondary reset not held");

	a_sreset_idle: assert property (
		s.sreset |=> s.fsm == ST_IDLE && s.cnt == '0
			&& !dt_discard_o
	) else $error("secondary logic not at default");

	a_cfg_kept: assert property (
		s.sreset && !wr |=> $stable(s.err_en)
			&& $stable(s.tmo_sel) && $stable(s.int_line)
	) else $error("configuration changed by reset bit");

	a_done_stops: assert property (
		s.fsm == ST_COUNT && dt_done_i
		|=> s.fsm == ST_IDLE && !s.discard ##1 !s.discard
	) else $error("repeat did not stop the timer");

	a_ack_once: assert property (
		s.ack |=> !s.ack
	) else $error("ack held for two cycles");

	a_discard_once: assert property (
		s.discard |=> !s.discard
	) else $error("discard held for two cycles");

	a_fatal_aer: assert property (
		err_msg_o && err_fatal_o |-> $past(aer_supported_i)
	) else $error("fatal message without error reporting");

	a_pci_only: assert property (
		!s.md_sync |=> !s.discard
	) else $error("discard outside PCI mode");

endmodule
`default_nettype wire

// ==== tb/sec_master_model.sv ====
// Secondary master model: PCI clock bursts, request repeats.
// Assumes the block clk; the PCI clock stays low between bursts.
`timescale 1ns/1ps
`default_nettype none
module sec_master_model (
	// Block clock
	input wire logic clk,
	// Secondary side
	output logic sec_pci_clk,
	output logic dt_done_i
);
	initial begin
		sec_pci_clk = 1'b0;
		dt_done_i = 1'b0;
	end
	// Burst of PCI clock cycles, 800 ns period
	task automatic pulses(input int n);
		#20;
		repeat (n) begin
			#400 sec_pci_clk = 1'b1;
			#400 sec_pci_clk = 1'b0;
		end
	endtask
	// Master repeats its request, completion delivered
	task automatic repeat_req();
		@(posedge clk);
		dt_done_i <= 1'b1;
		@(posedge clk);
		dt_done_i <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// Bench for the bridge control discard timer block.
// Assumes the design files and sec_master_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "bridge_ctrl_defines.svh"
module testbench;
	logic clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [7:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o;
	logic sec_pci_clk, sec_pci_mode, sec_rst_n_o, sec_init_o, fast_b2b_o;
	logic dt_head_i, dt_done_i, dt_discard_o, err_msg_o, err_fatal_o;
	logic aer_supported_i, aer_fatal_i, aer_mask_i, irq_o;
	logic msg_seen, fatal_seen;
	int failures = 0;
	int checks_done = 0;
	int discards = 0;
	bridge_control_discard_timer #(.TICKS_LONG(32'd64),
		.TICKS_SHORT(32'd8)) bridge_control_discard_timer_inst (.clk,
		.rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
		.wb_dat_i, .wb_dat_o, .wb_ack_o, .sec_pci_clk, .sec_pci_mode,
		.sec_rst_n_o, .sec_init_o, .fast_b2b_o, .dt_head_i, .dt_done_i,
		.dt_discard_o, .aer_supported_i, .aer_fatal_i, .aer_mask_i,
		.err_msg_o, .err_fatal_o, .irq_o);
	sec_master_model sec_master_model_inst (.clk, .sec_pci_clk,
		.dt_done_i);
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		if (dt_discard_o === 1'b1) begin
			discards <= discards + 1;
			msg_seen <= err_msg_o;
			fatal_seen <= err_fatal_o & err_msg_o;
		end
	end
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic check_bit(input string what, input logic exp,
		input logic got);
		check(what, {31'h0, exp}, {31'h0, got});
	endtask
	task automatic report_and_stop();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic wb_cycle(input logic we, input logic [7:0] adr,
		input logic [3:0] sel, input logic [31:0] wd,
		output logic [31:0] rd);
		int n;
		@(posedge clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_sel_i <= sel;
		wb_dat_i <= wd;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (n >= 20) begin
			failures++;
			report_and_stop();
		end
	endtask
	task automatic wr(input logic [7:0] adr, input logic [31:0] d);
		wr_part(adr, 4'hf, d);
	endtask
	task automatic wr_part(input logic [7:0] adr, input logic [3:0] sel,
		input logic [31:0] d);
		logic [31:0] rd;
		wb_cycle(1'b1, adr, sel, d, rd);
		repeat (2) @(posedge clk);
	endtask
	task automatic rd_check(input string what, input logic [7:0] adr,
		input logic [31:0] exp);
		logic [31:0] rd;
		wb_cycle(1'b0, adr, 4'hf, 32'h0, rd);
		@(posedge clk);
		check(what, exp, rd);
	endtask
	task automatic head_pulse();
		discards = 0;
		@(posedge clk);
		dt_head_i <= 1'b1;
		@(posedge clk);
		dt_head_i <= 1'b0;
	endtask
	task automatic expire(input int n, input logic msg, input logic fatal);
		head_pulse();
		sec_master_model_inst.pulses(n - 1);
		repeat (8) @(posedge clk);
		check_bit("early discard", 1'b0, discards != 0);
		sec_master_model_inst.pulses(1);
		repeat (8) @(posedge clk);
		check_bit("discard", 1'b1, discards == 1);
		check_bit("err msg", msg, msg_seen);
		check_bit("err fatal", fatal, fatal_seen);
	endtask
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		rst_n = 1'b0;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		dt_head_i = 1'b0;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'h0;
		wb_dat_i = 32'h0;
		aer_supported_i = 1'b0;
		aer_fatal_i = 1'b0;
		aer_mask_i = 1'b0;
		sec_pci_mode = 1'b1;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		rd_check("ctrl reset", `OFF_CTRL, 32'h000000ff);
		check_bit("sec rst", 1'b1, sec_rst_n_o);
		wr(`OFF_CTRL, 32'hffffffff);
		check_bit("sec rst on", 1'b0, sec_rst_n_o);
		check_bit("sec init", 1'b1, sec_init_o);
		check_bit("fast b2b", 1'b0, fast_b2b_o);
		rd_check("ctrl ones", `OFF_CTRL, 32'h0a4000ff);
		head_pulse();
		sec_master_model_inst.pulses(10);
		check_bit("held discard", 1'b0, discards != 0);
		wr(`OFF_CTRL, 32'h0a0000ff);
		check_bit("sec rst off", 1'b1, sec_rst_n_o);
		check_bit("sec init off", 1'b0, sec_init_o);
		rd_check("ctrl kept", `OFF_CTRL, 32'h0a0000ff);
		rd_check("irq release", `OFF_IRQ_STAT, 32'h4);
		wr(`OFF_IRQ_MASK, 32'h1);
		expire(8, 1'b1, 1'b0);
		check_bit("irq", 1'b1, irq_o);
		rd_check("ctrl stat", `OFF_CTRL, 32'h0e0000ff);
		rd_check("irq stat", `OFF_IRQ_STAT, 32'h1);
		check_bit("irq cleared", 1'b0, irq_o);
		wr(`OFF_CTRL, 32'h0e0000ff);
		rd_check("stat w1c", `OFF_CTRL, 32'h0a0000ff);
		head_pulse();
		sec_master_model_inst.pulses(4);
		sec_master_model_inst.repeat_req();
		sec_master_model_inst.pulses(10);
		check_bit("repeat discard", 1'b0, discards != 0);
		rd_check("irq done", `OFF_IRQ_STAT, 32'h2);
		sec_pci_mode <= 1'b0;
		repeat (4) @(posedge clk);
		head_pulse();
		sec_master_model_inst.pulses(10);
		check_bit("pcix discard", 1'b0, discards != 0);
		sec_pci_mode <= 1'b1;
		wr(`OFF_CTRL, 32'h020000ff);
		aer_supported_i <= 1'b1;
		aer_fatal_i <= 1'b1;
		expire(8, 1'b1, 1'b1);
		wr(`OFF_IRQ_MASK, 32'h0);
		wr(`OFF_CTRL, 32'h000000ff);
		aer_mask_i <= 1'b1;
		aer_fatal_i <= 1'b0;
		expire(64, 1'b0, 1'b0);
		check_bit("irq masked", 1'b0, irq_o);
		rd_check("unmapped", 8'h80, 32'h0);
		wr_part(`OFF_CTRL, 4'h1, 32'hffffff5a);
		rd_check("ctrl byte0", `OFF_CTRL, 32'h0400005a);
		wr_part(`OFF_CTRL, 4'h8, 32'h0c400000);
		rd_check("ctrl byte3", `OFF_CTRL, 32'h0800005a);
		check_bit("sec rst kept", 1'b1, sec_rst_n_o);
		report_and_stop();
	end
endmodule
`default_nettype wire
